// ===== uopsel_top.sv
`timescale 1ns/1ps
`default_nettype none
module uopsel_top
  import uopsel_pkg::*;
#(
  parameter int unsigned XCVR_N = UOPSEL_XCVR_N
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [UOPSEL_ADDR_W-1:0] reg_addr,
  input wire logic [UOPSEL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [UOPSEL_DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic [XCVR_N-1:0] rx_recovered_clock,
  input wire logic [XCVR_N-1:0] rx_loss_of_sync_flag,
  input wire logic [XCVR_N-1:0] rx_carrier_loss_flag,
  input wire logic [XCVR_N-1:0] rx_remote_alarm_flag,
  input wire logic [XCVR_N-1:0] rx_all_ones_flag,
  input wire logic [XCVR_N-1:0] rx_slip_flag,
  input wire logic [XCVR_N-1:0] rx_crc_error,
  input wire logic [XCVR_N-1:0] tx_clock_loss_flag,
  input wire logic [XCVR_N-1:0] recovered_frame_sync,
  input wire logic [XCVR_N-1:0] rx_prbs_error,
  input wire logic [XCVR_N-1:0] tx_nrz_data,
  input wire logic [XCVR_N-1:0] rx_serial_data,
  input wire logic [XCVR_N-1:0] rx_crc4_mf_sync,
  input wire logic [XCVR_N-1:0] rx_cas_mf_sync,
  input wire logic [XCVR_N-1:0] tx_current_limit,
  input wire logic [XCVR_N-1:0] tx_positive_rail,
  input wire logic [XCVR_N-1:0] tx_negative_rail,
  input wire logic [XCVR_N-1:0] receive_line_positive,
  input wire logic [XCVR_N-1:0] receive_line_negative,
  output logic [XCVR_N-1:0] user_out_first,
  output logic [XCVR_N-1:0] user_out_second,
  output logic [XCVR_N-1:0] nrz_input_enable,
  output logic [XCVR_N-1:0] rx_nrz_data,
  output logic [XCVR_N-1:0] rx_nrz_valid
);
  localparam int unsigned STAT_W = XCVR_N * UOPSEL_EVT_N;

  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_l;

  logic [UOPSEL_SIG_N-1:0][XCVR_N-1:0] raw;
  logic [UOPSEL_SIG_N-1:0][XCVR_N-1:0] sync1_reg;
  logic [UOPSEL_SIG_N-1:0][XCVR_N-1:0] sync2_reg;
  logic [UOPSEL_SIG_N-1:0][XCVR_N-1:0] prev_reg;

  logic [UOPSEL_CTRL_W-1:0] ctrl_first_reg [XCVR_N];
  logic [UOPSEL_CTRL_W-1:0] ctrl_first_next [XCVR_N];
  logic [UOPSEL_CTRL_W-1:0] ctrl_second_reg [XCVR_N];
  logic [UOPSEL_CTRL_W-1:0] ctrl_second_next [XCVR_N];
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] status_next;
  logic [STAT_W-1:0] mask_reg;
  logic [STAT_W-1:0] mask_next;
  logic [STAT_W-1:0] event_set;
  logic [UOPSEL_DATA_W-1:0] rdata_reg;
  logic [UOPSEL_DATA_W-1:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic [XCVR_N-1:0] nrz_data_reg;
  logic [XCVR_N-1:0] nrz_data_next;
  logic [XCVR_N-1:0] nrz_valid_reg;
  logic [XCVR_N-1:0] nrz_valid_next;
  logic [XCVR_N-1:0] nrz_en_out_reg;
  logic [XCVR_N-1:0] slip_p;
  logic [XCVR_N-1:0] crc_p;
  logic [XCVR_N-1:0] prbs_p;

  // control address of transceiver x, second pin when sel is set
  function automatic logic ctrl_hit(input logic [UOPSEL_ADDR_W-1:0] a, input int unsigned x,
                                    input logic sel);
    logic [UOPSEL_ADDR_W-1:0] t;
    t = UOPSEL_ADDR_CTRL_BASE + UOPSEL_ADDR_W'(2 * x) + UOPSEL_ADDR_W'(sel);
    return a == t;
  endfunction : ctrl_hit

  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction : rise

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_l = rst_s2_reg;

  always_comb begin
    raw[UOPSEL_S_RCLK] = rx_recovered_clock;
    raw[UOPSEL_S_LOS] = rx_loss_of_sync_flag;
    raw[UOPSEL_S_LCAR] = rx_carrier_loss_flag;
    raw[UOPSEL_S_RALM] = rx_remote_alarm_flag;
    raw[UOPSEL_S_AONES] = rx_all_ones_flag;
    raw[UOPSEL_S_SLIP] = rx_slip_flag;
    raw[UOPSEL_S_CRCE] = rx_crc_error;
    raw[UOPSEL_S_TCLKL] = tx_clock_loss_flag;
    raw[UOPSEL_S_FSYNC] = recovered_frame_sync;
    raw[UOPSEL_S_PRBSE] = rx_prbs_error;
    raw[UOPSEL_S_TDATA] = tx_nrz_data;
    raw[UOPSEL_S_RDATA] = rx_serial_data;
    raw[UOPSEL_S_CRCMF] = rx_crc4_mf_sync;
    raw[UOPSEL_S_CASMF] = rx_cas_mf_sync;
    raw[UOPSEL_S_ILIM] = tx_current_limit;
    raw[UOPSEL_S_TXP] = tx_positive_rail;
    raw[UOPSEL_S_TXN] = tx_negative_rail;
    raw[UOPSEL_S_LPOS] = receive_line_positive;
    raw[UOPSEL_S_LNEG] = receive_line_negative;
  end

  // all line-side inputs are asynchronous to clk
  always_ff @(posedge clk or negedge rst_l) begin
    if (!rst_l) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // events are rising edges so a wide source pulse counts once
  always_comb begin
    for (int x = 0; x < XCVR_N; x++) begin
      slip_p[x] = rise(sync2_reg[UOPSEL_S_SLIP][x], prev_reg[UOPSEL_S_SLIP][x]);
      crc_p[x] = rise(sync2_reg[UOPSEL_S_CRCE][x], prev_reg[UOPSEL_S_CRCE][x]);
      prbs_p[x] = rise(sync2_reg[UOPSEL_S_PRBSE][x], prev_reg[UOPSEL_S_PRBSE][x]);
    end
  end

  always_comb begin
    event_set = '0;
    for (int x = 0; x < XCVR_N; x++) begin
      event_set[x * UOPSEL_EVT_N + UOPSEL_EVT_SLIP] = slip_p[x];
      // crc errors during sync loss are not reported
      event_set[x * UOPSEL_EVT_N + UOPSEL_EVT_CRC] = crc_p[x] & ~sync2_reg[UOPSEL_S_LOS][x];
      event_set[x * UOPSEL_EVT_N + UOPSEL_EVT_PRBS] = prbs_p[x];
    end
  end

  always_comb begin
    mask_next = mask_reg;
    // set wins over a write-one clear in the same cycle
    status_next = status_reg;
    if (reg_wr && reg_addr == UOPSEL_ADDR_STATUS) begin
      status_next = status_reg & ~reg_wdata[STAT_W-1:0];
    end
    status_next = status_next | event_set;
    if (reg_wr && reg_addr == UOPSEL_ADDR_MASK) begin
      mask_next = reg_wdata[STAT_W-1:0];
    end
    irq_next = |(status_next & mask_next);
    for (int x = 0; x < XCVR_N; x++) begin
      ctrl_first_next[x] = ctrl_first_reg[x];
      ctrl_second_next[x] = ctrl_second_reg[x];
      if (reg_wr && ctrl_hit(reg_addr, x, 1'b0)) begin
        ctrl_first_next[x] = reg_wdata[UOPSEL_CTRL_W-1:0] & UOPSEL_FIRST_WMASK;
      end
      if (reg_wr && ctrl_hit(reg_addr, x, 1'b1)) begin
        ctrl_second_next[x] = reg_wdata[UOPSEL_CTRL_W-1:0] & UOPSEL_SECOND_WMASK;
      end
    end
    rdata_next = '0;
    if (reg_rd) begin
      if (reg_addr == UOPSEL_ADDR_STATUS) begin
        rdata_next[STAT_W-1:0] = status_reg;
      end else if (reg_addr == UOPSEL_ADDR_MASK) begin
        rdata_next[STAT_W-1:0] = mask_reg;
      end
      for (int x = 0; x < XCVR_N; x++) begin
        if (ctrl_hit(reg_addr, x, 1'b0)) begin
          rdata_next[UOPSEL_CTRL_W-1:0] = ctrl_first_reg[x];
        end
        if (ctrl_hit(reg_addr, x, 1'b1)) begin
          rdata_next[UOPSEL_CTRL_W-1:0] = ctrl_second_reg[x];
        end
      end
    end
  end

  always_comb begin
    for (int x = 0; x < XCVR_N; x++) begin
      // sample data on falling edge of clock input
      nrz_valid_next[x] = ctrl_second_reg[x][UOPSEL_NRZ_EN_BIT]
                          & prev_reg[UOPSEL_S_LNEG][x] & ~sync2_reg[UOPSEL_S_LNEG][x];
      nrz_data_next[x] = nrz_valid_next[x] ? sync2_reg[UOPSEL_S_LPOS][x] : nrz_data_reg[x];
    end
  end

  always_ff @(posedge clk or negedge rst_l) begin
    if (!rst_l) begin
      for (int x = 0; x < XCVR_N; x++) begin
        ctrl_first_reg[x] <= UOPSEL_CTRL_RST;
        ctrl_second_reg[x] <= UOPSEL_CTRL_RST;
      end
      status_reg <= UOPSEL_STAT_RST[STAT_W-1:0];
      mask_reg <= UOPSEL_STAT_RST[STAT_W-1:0];
      rdata_reg <= '0;
      irq_reg <= 1'b0;
      nrz_data_reg <= '0;
      nrz_valid_reg <= '0;
      nrz_en_out_reg <= '0;
    end else begin
      ctrl_first_reg <= ctrl_first_next;
      ctrl_second_reg <= ctrl_second_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      nrz_data_reg <= nrz_data_next;
      nrz_valid_reg <= nrz_valid_next;
      for (int x = 0; x < XCVR_N; x++) begin
        nrz_en_out_reg[x] <= ctrl_second_next[x][UOPSEL_NRZ_EN_BIT];
      end
    end
  end

  for (genvar g = 0; g < XCVR_N; g++) begin : g_xcvr
    uopsel_src_if src_bus ();
    always_comb begin
      for (int s = 0; s < UOPSEL_SIG_N; s++) begin
        src_bus.lvl[s] = sync2_reg[s][g];
      end
      src_bus.slip_p = slip_p[g];
      src_bus.crc_p = crc_p[g];
      src_bus.prbs_p = prbs_p[g];
    end
    uopsel_pin_mux u_mux (
      .clk(clk),
      .rst_l(rst_l),
      .ctrl_first(ctrl_first_reg[g]),
      .ctrl_second(ctrl_second_reg[g]),
      .src(src_bus.sink),
      .user_out_first(user_out_first[g]),
      .user_out_second(user_out_second[g])
    );
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign nrz_input_enable = nrz_en_out_reg;
  assign rx_nrz_data = nrz_data_reg;
  assign rx_nrz_valid = nrz_valid_reg;
endmodule : uopsel_top
`default_nettype wire

// ===== uopsel_pkg.sv
package uopsel_pkg;
  localparam int unsigned UOPSEL_XCVR_N = 4;
  localparam int unsigned UOPSEL_ADDR_W = 8;
  localparam int unsigned UOPSEL_DATA_W = 16;
  localparam int unsigned UOPSEL_CTRL_W = 8;
  localparam int unsigned UOPSEL_EVT_N = 3;

  // control register fields
  localparam int unsigned UOPSEL_NRZ_EN_BIT = 7;
  localparam int unsigned UOPSEL_INV_BIT = 4;
  localparam int unsigned UOPSEL_FUNC_MSB = 3;
  localparam int unsigned UOPSEL_FUNC_LSB = 0;
  localparam logic [7:0] UOPSEL_CTRL_RST = 8'h00;
  localparam logic [7:0] UOPSEL_FIRST_WMASK = 8'h1f;
  localparam logic [7:0] UOPSEL_SECOND_WMASK = 8'h9f;

  // register map: first control at 2*x, second control at 2*x+1
  localparam logic [7:0] UOPSEL_ADDR_CTRL_BASE = 8'h00;
  localparam logic [7:0] UOPSEL_ADDR_STATUS = 8'h10;
  localparam logic [7:0] UOPSEL_ADDR_MASK = 8'h11;
  localparam logic [15:0] UOPSEL_STAT_RST = 16'h0000;

  // event bits inside one transceiver's slice of status/mask
  localparam int unsigned UOPSEL_EVT_SLIP = 0;
  localparam int unsigned UOPSEL_EVT_CRC = 1;
  localparam int unsigned UOPSEL_EVT_PRBS = 2;

  // index of each incoming line-side signal in the sampled vector
  localparam int unsigned UOPSEL_S_RCLK = 0;
  localparam int unsigned UOPSEL_S_LOS = 1;
  localparam int unsigned UOPSEL_S_LCAR = 2;
  localparam int unsigned UOPSEL_S_RALM = 3;
  localparam int unsigned UOPSEL_S_AONES = 4;
  localparam int unsigned UOPSEL_S_SLIP = 5;
  localparam int unsigned UOPSEL_S_CRCE = 6;
  localparam int unsigned UOPSEL_S_TCLKL = 7;
  localparam int unsigned UOPSEL_S_FSYNC = 8;
  localparam int unsigned UOPSEL_S_PRBSE = 9;
  localparam int unsigned UOPSEL_S_TDATA = 10;
  localparam int unsigned UOPSEL_S_RDATA = 11;
  localparam int unsigned UOPSEL_S_CRCMF = 12;
  localparam int unsigned UOPSEL_S_CASMF = 13;
  localparam int unsigned UOPSEL_S_ILIM = 14;
  localparam int unsigned UOPSEL_S_TXP = 15;
  localparam int unsigned UOPSEL_S_TXN = 16;
  localparam int unsigned UOPSEL_S_LPOS = 17;
  localparam int unsigned UOPSEL_S_LNEG = 18;
  localparam int unsigned UOPSEL_SIG_N = 19;

  typedef enum logic [3:0] {
    UOPSEL_F_STATIC = 4'h0,
    UOPSEL_F_RCLK = 4'h1,
    UOPSEL_F_LOS = 4'h2,
    UOPSEL_F_LCAR = 4'h3,
    UOPSEL_F_RALM = 4'h4,
    UOPSEL_F_AONES = 4'h5,
    UOPSEL_F_SLIP = 4'h6,
    UOPSEL_F_CRCE = 4'h7,
    UOPSEL_F_TCLKL = 4'h8,
    UOPSEL_F_FSYNC = 4'h9,
    UOPSEL_F_PRBSE = 4'ha,
    UOPSEL_F_DATA = 4'hb,
    UOPSEL_F_CRCMF = 4'hc,
    UOPSEL_F_CASMF = 4'hd,
    UOPSEL_F_ILIM = 4'he,
    UOPSEL_F_RAILS = 4'hf
  } uopsel_func_t;
endpackage : uopsel_pkg

// ===== uopsel_src_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uopsel_src_if;
  import uopsel_pkg::*;
  logic [UOPSEL_SIG_N-1:0] lvl;
  logic slip_p;
  logic crc_p;
  logic prbs_p;
  modport src (output lvl, output slip_p, output crc_p, output prbs_p);
  modport sink (input lvl, input slip_p, input crc_p, input prbs_p);
endinterface : uopsel_src_if
`default_nettype wire

// ===== uopsel_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module uopsel_pin_mux
  import uopsel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_l,
  input wire logic [UOPSEL_CTRL_W-1:0] ctrl_first,
  input wire logic [UOPSEL_CTRL_W-1:0] ctrl_second,
  uopsel_src_if.sink src,
  output logic user_out_first,
  output logic user_out_second
);
  logic out_first_reg;
  logic out_first_next;
  logic out_second_reg;
  logic out_second_next;

  // second selects whether this is the second pin (rail and data split)
  function automatic logic pick(input logic [3:0] code, input logic second,
                                input logic [UOPSEL_SIG_N-1:0] l,
                                input logic slip, input logic crc, input logic prbs);
    logic v;
    v = 1'b0;
    case (code)
      UOPSEL_F_STATIC: v = 1'b0;
      UOPSEL_F_RCLK: v = l[UOPSEL_S_RCLK];
      UOPSEL_F_LOS: v = l[UOPSEL_S_LOS];
      UOPSEL_F_LCAR: v = l[UOPSEL_S_LCAR];
      UOPSEL_F_RALM: v = l[UOPSEL_S_RALM];
      UOPSEL_F_AONES: v = l[UOPSEL_S_AONES];
      UOPSEL_F_SLIP: v = slip;
      UOPSEL_F_CRCE: v = crc & ~l[UOPSEL_S_LOS];
      UOPSEL_F_TCLKL: v = l[UOPSEL_S_TCLKL];
      UOPSEL_F_FSYNC: v = l[UOPSEL_S_FSYNC];
      UOPSEL_F_PRBSE: v = prbs;
      UOPSEL_F_DATA: v = second ? l[UOPSEL_S_TDATA] : l[UOPSEL_S_RDATA];
      UOPSEL_F_CRCMF: v = l[UOPSEL_S_CRCMF];
      UOPSEL_F_CASMF: v = l[UOPSEL_S_CASMF];
      UOPSEL_F_ILIM: v = l[UOPSEL_S_ILIM];
      UOPSEL_F_RAILS: v = second ? l[UOPSEL_S_TXP] : l[UOPSEL_S_TXN];
      default: v = 1'b0;
    endcase
    return v;
  endfunction : pick

  always_comb begin
    out_first_next = pick(ctrl_first[UOPSEL_FUNC_MSB:UOPSEL_FUNC_LSB], 1'b0, src.lvl,
                          src.slip_p, src.crc_p, src.prbs_p) ^ ctrl_first[UOPSEL_INV_BIT];
    out_second_next = pick(ctrl_second[UOPSEL_FUNC_MSB:UOPSEL_FUNC_LSB], 1'b1, src.lvl,
                           src.slip_p, src.crc_p, src.prbs_p) ^ ctrl_second[UOPSEL_INV_BIT];
  end

  always_ff @(posedge clk or negedge rst_l) begin
    if (!rst_l) begin
      out_first_reg <= 1'b0;
      out_second_reg <= 1'b0;
    end else begin
      out_first_reg <= out_first_next;
      out_second_reg <= out_second_next;
    end
  end

  assign user_out_first = out_first_reg;
  assign user_out_second = out_second_reg;
endmodule : uopsel_pin_mux
`default_nettype wire

// ===== uopsel_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module uopsel_line_model (
  input wire logic clk,
  input wire logic run,
  input wire logic slow,
  output logic [3:0] rclk,
  output logic [3:0] fsync,
  output logic [3:0] lpos,
  output logic [3:0] lneg
);
  logic [2:0] ph;
  logic tick;
  initial begin
    ph = 3'h0;
    rclk = 4'h0;
    fsync = 4'h0;
    lpos = 4'h5;
    lneg = 4'hf;
  end
  assign tick = slow ? ph[1:0] == 2'h3 : ph[0];
  // line clock parks high between bursts; released data keeps moving
  always @(posedge clk) begin
    if (run) begin
      ph <= ph + 3'h1;
      fsync <= {4{ph == 3'h7}};
      if (tick) begin
        rclk <= ~rclk;
        lneg <= ~lneg;
        // data moves on the rise so it is steady at the sampling fall
        if (!lneg[0]) begin
          lpos <= lpos ^ {ph, 1'b1};
        end
      end
    end else begin
      lneg <= 4'hf;
      lpos <= ~lpos;
      fsync <= 4'h0;
    end
  end
endmodule : uopsel_line_model
`default_nettype wire

// ===== uopsel_chk.sv
`timescale 1ns/1ps
`default_nettype none
module uopsel_chk
  import uopsel_pkg::*;
#(
  parameter int unsigned XCVR_N = UOPSEL_XCVR_N
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [UOPSEL_ADDR_W-1:0] reg_addr,
  input wire logic [UOPSEL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [XCVR_N-1:0] rx_recovered_clock,
  input wire logic [XCVR_N-1:0] rx_loss_of_sync_flag,
  input wire logic [XCVR_N-1:0] rx_carrier_loss_flag,
  input wire logic [XCVR_N-1:0] rx_slip_flag,
  input wire logic [XCVR_N-1:0] tx_positive_rail,
  input wire logic [XCVR_N-1:0] tx_negative_rail,
  input wire logic [XCVR_N-1:0] user_out_first,
  input wire logic [XCVR_N-1:0] user_out_second,
  input wire logic [XCVR_N-1:0] nrz_input_enable,
  input wire logic [XCVR_N-1:0] rx_nrz_valid
);
  logic [7:0] f_reg, f_next, s_reg, s_next;
  logic [2:0] q_reg, q_next;
  logic wr0, wr1, a_lvl;
  // shadow of transceiver 0 controls; q counts quiet cycles since a write
  always_comb begin
    wr0 = reg_wr && reg_addr == 8'h00;
    wr1 = reg_wr && reg_addr == 8'h01;
    f_next = wr0 ? reg_wdata[7:0] & 8'h1f : f_reg;
    s_next = wr1 ? reg_wdata[7:0] & 8'h9f : s_reg;
    q_next = (wr0 || wr1) ? 3'h0 : q_reg + {2'h0, q_reg != 3'h7};
    case (f_reg[3:0])
      4'h1: a_lvl = rx_recovered_clock[0];
      4'h2: a_lvl = rx_loss_of_sync_flag[0];
      4'h3: a_lvl = rx_carrier_loss_flag[0];
      4'hf: a_lvl = tx_negative_rail[0];
      default: a_lvl = 1'b0;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_reg <= 8'h00;
      s_reg <= 8'h00;
      q_reg <= 3'h0;
    end else begin
      f_reg <= f_next;
      s_reg <= s_next;
      q_reg <= q_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_static_first: assert property (q_reg == 3'h7 && f_reg[3:0] == 4'h0 |-> user_out_first[0] == f_reg[4])
    else $error("first pin not at static level");
  a_static_second: assert property (q_reg == 3'h7 && s_reg[3:0] == 4'h0 |-> user_out_second[0] == s_reg[4])
    else $error("second pin not at static level");
  a_first_level: assert property ((q_reg == 3'h7 && f_reg[3:0] inside {4'h1, 4'h2, 4'h3, 4'hf} &&
    $stable(a_lvl)) [*4] |-> user_out_first[0] == (a_lvl ^ f_reg[4])) else $error("first pin source wrong");
  a_second_rail: assert property ((q_reg == 3'h7 && s_reg[3:0] == 4'hf && $stable(tx_positive_rail[0])) [*4]
    |-> user_out_second[0] == (tx_positive_rail[0] ^ s_reg[4])) else $error("second pin rail wrong");
  a_slip_pulse: assert property (q_reg == 3'h7 && f_reg[4:0] == 5'h06 && $rose(rx_slip_flag[0])
    |-> ##[1:5] user_out_first[0]) else $error("slip pulse missing");
  a_pulse_single: assert property (q_reg == 3'h7 && f_reg[3:0] inside {4'h6, 4'h7, 4'ha} &&
    (user_out_first[0] ^ f_reg[4]) |=> !(user_out_first[0] ^ f_reg[4])) else $error("event pulse too wide");
  a_crc_blank: assert property ((q_reg == 3'h7 && f_reg[3:0] == 4'h7 && rx_loss_of_sync_flag[0]) [*6]
    |-> !(user_out_first[0] ^ f_reg[4])) else $error("crc pulse during sync loss");
  a_nrz_copy: assert property (q_reg == 3'h7 |-> nrz_input_enable[0] == s_reg[7])
    else $error("nrz enable does not follow control");
  a_nrz_idle: assert property (q_reg == 3'h7 && !s_reg[7] |-> !rx_nrz_valid[0])
    else $error("nrz sample while disabled");
  c_slip: cover property (f_reg[3:0] == 4'h6 && user_out_first[0]);
  c_nrz: cover property (rx_nrz_valid[0]);
  c_rail: cover property (q_reg == 3'h7 && s_reg[3:0] == 4'hf);
endmodule : uopsel_chk
bind uopsel_top uopsel_chk #(.XCVR_N(XCVR_N)) u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .rx_recovered_clock, .rx_loss_of_sync_flag, .rx_carrier_loss_flag, .rx_slip_flag, .tx_positive_rail,
  .tx_negative_rail, .user_out_first, .user_out_second, .nrz_input_enable, .rx_nrz_valid);
`default_nettype wire

// ===== uopsel_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  import uopsel_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0, slow = 1'b0, ln_d = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [3:0] rx_loss_of_sync_flag = 0, rx_carrier_loss_flag = 0, rx_remote_alarm_flag = 0, rx_all_ones_flag = 0;
  logic [3:0] tx_clock_loss_flag = 0, tx_nrz_data = 0, rx_serial_data = 0, rx_crc4_mf_sync = 0, rx_cas_mf_sync = 0;
  logic [3:0] tx_current_limit = 0, tx_positive_rail = 0, tx_negative_rail = 0;
  logic [3:0] rx_slip_flag = 0, rx_crc_error = 0, rx_prbs_error = 0;
  wire [3:0] rx_recovered_clock, recovered_frame_sync, receive_line_positive, receive_line_negative;
  wire [3:0] user_out_first, user_out_second, nrz_input_enable, rx_nrz_data, rx_nrz_valid;
  wire [15:0] reg_rdata;
  wire irq;
  int n_fail = 0, n_tests = 0, n_v = 0, n_f = 0;
  logic [31:0] seed = 32'h46dcaf8a;
  logic [7:0] fc [4];
  logic [7:0] sc [4];
  logic q [$];
  always #25 clk = ~clk;
  uopsel_line_model u_line (.clk, .run, .slow, .rclk(rx_recovered_clock), .fsync(recovered_frame_sync),
    .lpos(receive_line_positive), .lneg(receive_line_negative));
  uopsel_top u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .rx_recovered_clock,
    .rx_loss_of_sync_flag, .rx_carrier_loss_flag, .rx_remote_alarm_flag, .rx_all_ones_flag, .rx_slip_flag,
    .rx_crc_error, .tx_clock_loss_flag, .recovered_frame_sync, .rx_prbs_error, .tx_nrz_data, .rx_serial_data,
    .rx_crc4_mf_sync, .rx_cas_mf_sync, .tx_current_limit, .tx_positive_rail, .tx_negative_rail,
    .receive_line_positive, .receive_line_negative, .user_out_first, .user_out_second, .nrz_input_enable,
    .rx_nrz_data, .rx_nrz_valid);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic ep(input int x, input logic sec);
    logic [7:0] c;
    logic v;
    c = sec ? sc[x] : fc[x];
    case (c[3:0])
      4'h1: v = rx_recovered_clock[x];
      4'h2: v = rx_loss_of_sync_flag[x];
      4'h3: v = rx_carrier_loss_flag[x];
      4'h4: v = rx_remote_alarm_flag[x];
      4'h5: v = rx_all_ones_flag[x];
      4'h8: v = tx_clock_loss_flag[x];
      4'h9: v = recovered_frame_sync[x];
      4'hb: v = sec ? tx_nrz_data[x] : rx_serial_data[x];
      4'hc: v = rx_crc4_mf_sync[x];
      4'hd: v = rx_cas_mf_sync[x];
      4'he: v = tx_current_limit[x];
      4'hf: v = sec ? tx_positive_rail[x] : tx_negative_rail[x];
      default: v = 1'b0;
    endcase
    return v ^ c[4];
  endfunction : ep
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic ev(input logic [3:0] c, input int k, input logic los);
    int n;
    logic [15:0] e;
    n = 0;
    e = (c == 4'h7 && los) ? 16'h0000 : 16'h0001 << k;
    wr(8'h00, {12'h000, c});
    wr(8'h11, 16'h0000);
    rx_loss_of_sync_flag <= {4{los}};
    repeat (8) @(posedge clk);
    {rx_prbs_error[0], rx_crc_error[0], rx_slip_flag[0]} <= 3'h1 << k;
    repeat (2) @(posedge clk);
    {rx_prbs_error[0], rx_crc_error[0], rx_slip_flag[0]} <= 3'h0;
    repeat (10) begin
      @(negedge clk);
      if (user_out_first[0] !== 1'b0) n++;
    end
    `CHK(n, (e == 0) ? 0 : 1)
    `CHK(irq, 1'b0)
    rd(8'h10, e);
    wr(8'h11, 16'h0fff);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(irq, e != 0)
    wr(8'h10, 16'h0fff);
    rd(8'h10, 16'h0000);
    `CHK(irq, 1'b0)
    rx_loss_of_sync_flag <= 4'h0;
    $display("test event %h done", c);
  endtask : ev
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  always @(negedge clk) begin
    ln_d <= receive_line_negative[0];
    if (ln_d && !receive_line_negative[0]) begin
      q.push_back(receive_line_positive[0]);
      n_f++;
    end
    if (rx_nrz_valid[0] !== 1'b0) begin
      n_v++;
      if (q.size() > 0) `CHK(rx_nrz_data[0], q.pop_front())
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    logic [63:0] r64;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 8; a++) rd(8'(a), 16'h0000);
    wr(8'h20, 16'hffff);
    rd(8'h20, 16'h0000);
    rd(8'h10, 16'h0000);
    rd(8'h11, 16'h0000);
    `CHK(user_out_first | user_out_second, 4'h0)
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      for (int x = 0; x < 4; x++) begin
        r = rnd();
        fc[x] = r[7:0] & 8'h1f;
        sc[x] = r[15:8] & 8'h1f;
      end
      fc[0][3:0] = 4'(i);
      sc[0][3:0] = 4'hf - 4'(i);
      for (int x = 0; x < 4; x++) begin
        wr(8'(2 * x), {8'h00, fc[x]});
        wr(8'(2 * x + 1), {8'h00, sc[x]});
      end
      r64 = {rnd(), rnd()};
      {rx_loss_of_sync_flag, rx_carrier_loss_flag, rx_remote_alarm_flag, rx_all_ones_flag, tx_clock_loss_flag,
        tx_nrz_data, rx_serial_data, rx_crc4_mf_sync, rx_cas_mf_sync, tx_current_limit, tx_positive_rail,
        tx_negative_rail} <= r64[47:0];
      repeat (8) @(posedge clk);
      @(negedge clk);
      for (int x = 0; x < 4; x++) begin
        `CHK(user_out_first[x], ep(x, 1'b0))
        `CHK(user_out_second[x], ep(x, 1'b1))
      end
    end
    rd(8'h01, {8'h00, sc[0]});
    $display("test source table done");
    ev(4'h6, 0, 1'b0);
    ev(4'h7, 1, 1'b0);
    ev(4'h7, 1, 1'b1);
    ev(4'ha, 2, 1'b0);
    wr(8'h01, 16'h0090);
    rd(8'h01, 16'h0090);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(nrz_input_enable[0], 1'b1)
    `CHK(user_out_second[0], 1'b1)
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      slow <= s[0];
      run <= 1'b1;
      repeat (64) @(posedge clk);
      run <= 1'b0;
      repeat (10) @(posedge clk);
    end
    `CHK(n_v, n_f)
    `CHK(n_f > 4, 1'b1)
    wr(8'h01, 16'h0000);
    $display("test nrz input done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
